//--- rtl/rtcc_pkg.sv
// package for the calendar, timekeeping trim and weekly alarm block
// assumes one system clock and a one-cycle crystal tick enable
package rtcc_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_DAY       = 4'h4;
    localparam logic [3:0] ADDR_MONTH     = 4'h5;
    localparam logic [3:0] ADDR_YEAR      = 4'h6;
    localparam logic [3:0] ADDR_TRIM      = 4'h7;
    localparam logic [3:0] ADDR_WA_MINUTE = 4'h8;
    localparam logic [3:0] ADDR_WA_HOUR   = 4'h9;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CENTURY_BIT   = 7;
    localparam int TRIM_DIR_BIT  = 6;
    localparam int WA_HOUR_D5    = 5;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [5:0] DAY_RESET   = 6'h01;
    localparam logic [4:0] MONTH_RESET = 5'h01;
    localparam logic [7:0] YEAR_RESET  = 8'h00;
    localparam logic [6:0] TRIM_RESET  = 7'h00;
    localparam logic [6:0] WA_MIN_RESET  = 7'h00;
    localparam logic [5:0] WA_HOUR_RESET = 6'h12;

    // ----------------------------------------
    // calendar limits
    // ----------------------------------------
    localparam logic [4:0] MONTH_LAST = 5'h12;
    localparam logic [7:0] YEAR_LAST  = 8'h99;
    localparam logic [4:0] MONTH_FEB  = 5'h02;

    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int XTAL_HZ = 32768;
    localparam logic [15:0] SEC_COUNT = 16'(XTAL_HZ);
    localparam logic [6:0]  SEC_PT_00 = 7'h00;
    localparam logic [6:0]  SEC_PT_20 = 7'h20;
    localparam logic [6:0]  SEC_PT_40 = 7'h40;

    // ----------------------------------------
    // bcd helpers
    // ----------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = 1'b0;
        if (y[4] == 1'b0) begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return r;
    endfunction

    function automatic logic [5:0] last_day(input logic [4:0] m, input logic leap);
        logic [5:0] r;
        r = 6'h31;
        unique case (m)
            5'h04, 5'h06, 5'h09, 5'h11: r = 6'h30;
            5'h02:                      r = leap ? 6'h29 : 6'h28;
            default:                    r = 6'h31;
        endcase
        return r;
    endfunction

endpackage

//--- rtl/rtcc_trim_timer.sv
// one-second divider with trim at the 00, 20 and 40 second points
// assumes xtal_tick is a one-cycle enable at the crystal rate
`timescale 1ns/100ps
module rtcc_trim_timer (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       xtal_tick,
    input  wire logic [6:0] sec_value,
    input  wire logic [6:0] trim_value,
    input  wire logic       trim_wr,
    input  wire logic       osc_halt_flag,
    output logic            second_tick_reg
);

    logic [15:0] cnt_reg;
    logic        trim_en_reg;
    logic        skip_reg;
    logic        at_point;
    logic        apply;
    logic [15:0] period_len;

    // ----------------------------------------
    // period length
    // ----------------------------------------
    assign at_point = (sec_value == rtcc_pkg::SEC_PT_00) || (sec_value == rtcc_pkg::SEC_PT_20)
                    || (sec_value == rtcc_pkg::SEC_PT_40);
    assign apply = trim_en_reg && at_point && !skip_reg && (trim_value[5:1] != 5'h00);

    always_comb begin
        period_len = rtcc_pkg::SEC_COUNT;
        if (apply) begin
            if (!trim_value[rtcc_pkg::TRIM_DIR_BIT]) begin
                period_len = rtcc_pkg::SEC_COUNT + {9'h000, trim_value[5:0] - 6'h01, 1'b0};
            end else begin
                period_len = rtcc_pkg::SEC_COUNT - {8'h00, 7'({1'b0, ~trim_value[5:0]}) + 7'h01, 1'b0};
            end
        end
    end

    // ----------------------------------------
    // trim enable and write-point skip
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trim_en_reg <= 1'b0;
        end else if (osc_halt_flag) begin
            trim_en_reg <= 1'b0;
        end else if (trim_wr) begin
            trim_en_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            skip_reg <= 1'b0;
        end else if (trim_wr && at_point) begin
            skip_reg <= 1'b1;
        end else if (second_tick_reg) begin
            skip_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // counter, count only not crystal
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg         <= 16'h0000;
            second_tick_reg <= 1'b0;
        end else begin
            second_tick_reg <= 1'b0;
            if (xtal_tick) begin
                if (cnt_reg >= period_len - 16'h0001) begin
                    cnt_reg         <= 16'h0000;
                    second_tick_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
        end
    end

    chk_trim_neutral: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (trim_value[5:1] == 5'h00) |-> (period_len == rtcc_pkg::SEC_COUNT))
        else $error("neutral trim changed the second");
    chk_trim_points: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !at_point |-> (period_len == rtcc_pkg::SEC_COUNT))
        else $error("trim applied off the trim points");
    chk_write_skip: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (trim_wr && at_point && !second_tick_reg) |=> (period_len == rtcc_pkg::SEC_COUNT))
        else $error("trim applied in the second of its write");

endmodule

//--- rtl/rtcc_calendar.sv
// calendar counters, trim register and weekly alarm minute and hour
// assumes a register port driven by a serial protocol engine elsewhere
//
// Summary of operation
// - day counts bcd 1..31 or 1..30 by month
// - february ends at 29 in leap years, 28 otherwise
// - day wrap from last day increments the month
// - month counts 1..12; wrap from 12 increments the year
// - year counts 00..99; multiples of four, 00 included, are leap
// - century flag toggles on year wrap 99 to 00
// - day six bits, month five plus century, year eight, packed bcd
// - oscillation halt clears the trim register to zero
// - untrimmed second lasts 32768 crystal cycles
// - trim only touches seconds 00, 20 and 40
// - trim write enables trim, not at the point of the write
// - direction 0 lengthens second by 2*(magnitude-1)
// - direction 1 shortens second by 2*(inverse magnitude+1)
// - middle five trim bits zero means no change
// - trim alters the count only, two cycles a step
// - alarm hour bit D5 is pm flag or hour twenty bit
// - 12-hour alarm hours encode midnight 12 and noon 32
// - all weekday enables zero suppress the weekly alarm
`timescale 1ns/100ps
module rtcc_calendar (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       xtal_tick,
    input  wire logic       osc_halt_flag,
    input  wire logic [6:0] sec_value,
    input  wire logic       day_carry,
    input  wire logic [6:0] weekly_alarm_day_enables,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_reg,
    output logic            second_tick_reg,
    output logic [5:0]      day_reg,
    output logic [4:0]      month_reg,
    output logic            century_reg,
    output logic [7:0]      year_reg,
    output logic [6:0]      wa_min_reg,
    output logic [5:0]      wa_hour_reg,
    output logic            weekly_alarm_on_reg
);

    logic [6:0] trim_reg;
    logic       wr_day;
    logic       wr_month;
    logic       wr_year;
    logic       wr_trim;
    logic       leap;
    logic [5:0] month_end;
    logic       day_wrap;
    logic       month_wrap;
    logic       year_wrap;
    logic [7:0] rd_next;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign wr_day   = reg_wr && (reg_addr == rtcc_pkg::ADDR_DAY);
    assign wr_month = reg_wr && (reg_addr == rtcc_pkg::ADDR_MONTH);
    assign wr_year  = reg_wr && (reg_addr == rtcc_pkg::ADDR_YEAR);
    assign wr_trim  = reg_wr && (reg_addr == rtcc_pkg::ADDR_TRIM);

    assign leap       = rtcc_pkg::is_leap(year_reg);
    assign month_end  = rtcc_pkg::last_day(month_reg, leap);
    assign day_wrap   = day_carry && (day_reg == month_end);
    assign month_wrap = day_wrap && (month_reg == rtcc_pkg::MONTH_LAST);
    assign year_wrap  = month_wrap && (year_reg == rtcc_pkg::YEAR_LAST);

    // ----------------------------------------
    // day of month
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            day_reg <= rtcc_pkg::DAY_RESET;
        end else if (wr_day) begin
            day_reg <= reg_wdata[5:0];
        end else if (day_carry) begin
            if (day_wrap) begin
                day_reg <= rtcc_pkg::DAY_RESET;
            end else begin
                day_reg <= 6'(rtcc_pkg::bcd_inc({2'b00, day_reg}));
            end
        end
    end

    // ----------------------------------------
    // month and century
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            month_reg <= rtcc_pkg::MONTH_RESET;
        end else if (wr_month) begin
            month_reg <= reg_wdata[4:0];
        end else if (day_wrap) begin
            if (month_wrap) begin
                month_reg <= rtcc_pkg::MONTH_RESET;
            end else begin
                month_reg <= 5'(rtcc_pkg::bcd_inc({3'b000, month_reg}));
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            century_reg <= 1'b0;
        end else if (wr_month) begin
            century_reg <= reg_wdata[rtcc_pkg::CENTURY_BIT];
        end else if (year_wrap) begin
            century_reg <= ~century_reg;
        end
    end

    // ----------------------------------------
    // year
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            year_reg <= rtcc_pkg::YEAR_RESET;
        end else if (wr_year) begin
            year_reg <= reg_wdata;
        end else if (month_wrap) begin
            if (year_wrap) begin
                year_reg <= rtcc_pkg::YEAR_RESET;
            end else begin
                year_reg <= rtcc_pkg::bcd_inc(year_reg);
            end
        end
    end

    // ----------------------------------------
    // trim register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trim_reg <= rtcc_pkg::TRIM_RESET;
        end else if (osc_halt_flag) begin
            trim_reg <= rtcc_pkg::TRIM_RESET;
        end else if (wr_trim) begin
            trim_reg <= reg_wdata[6:0];
        end
    end

    rtcc_trim_timer u_trim_timer (
        .clk_sys         (clk_sys),
        .arst_n          (arst_n),
        .xtal_tick       (xtal_tick),
        .sec_value       (sec_value),
        .trim_value      (trim_reg),
        .trim_wr         (wr_trim && !osc_halt_flag),
        .osc_halt_flag   (osc_halt_flag),
        .second_tick_reg (second_tick_reg)
    );

    // ----------------------------------------
    // weekly alarm minute and hour
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wa_min_reg <= rtcc_pkg::WA_MIN_RESET;
        end else if (reg_wr && (reg_addr == rtcc_pkg::ADDR_WA_MINUTE)) begin
            wa_min_reg <= reg_wdata[6:0];
        end
    end

    // d5 kept raw: pm flag or hour twenty bit, 12 and 32 encodings kept as written
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wa_hour_reg <= rtcc_pkg::WA_HOUR_RESET;
        end else if (reg_wr && (reg_addr == rtcc_pkg::ADDR_WA_HOUR)) begin
            wa_hour_reg <= reg_wdata[rtcc_pkg::WA_HOUR_D5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            weekly_alarm_on_reg <= 1'b0;
        end else begin
            weekly_alarm_on_reg <= |weekly_alarm_day_enables;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        rd_next = 8'h00;
        unique case (reg_addr)
            rtcc_pkg::ADDR_DAY:       rd_next = {2'b00, day_reg};
            rtcc_pkg::ADDR_MONTH:     rd_next = {century_reg, 2'b00, month_reg};
            rtcc_pkg::ADDR_YEAR:      rd_next = year_reg;
            rtcc_pkg::ADDR_TRIM:      rd_next = {1'b0, trim_reg};
            rtcc_pkg::ADDR_WA_MINUTE: rd_next = {1'b0, wa_min_reg};
            rtcc_pkg::ADDR_WA_HOUR:   rd_next = {2'b00, wa_hour_reg};
            default:                  rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_day_wrap: assert property (
        (day_wrap && !reg_wr) |=> (day_reg == 6'h01) && (month_reg != $past(month_reg)))
        else $error("day wrap did not restart day and move month");
    chk_day_limit: assert property (
        (day_carry && !reg_wr && day_reg == 6'h30 && month_reg == 5'h04) |=> (day_reg == 6'h01))
        else $error("thirty-day month passed day 30");
    chk_leap_feb: assert property (
        (day_carry && !reg_wr && day_reg == 6'h28 && month_reg == rtcc_pkg::MONTH_FEB && leap)
        |=> (day_reg == 6'h29) ##0 (month_reg == rtcc_pkg::MONTH_FEB))
        else $error("leap february did not reach 29");
    chk_month_wrap: assert property (
        (month_wrap && !reg_wr) |=> (month_reg == 5'h01)
        && ((year_reg == 8'(rtcc_pkg::bcd_inc($past(year_reg)))) || (year_reg == 8'h00)))
        else $error("month wrap did not step the year");
    chk_century_toggle: assert property (
        (year_wrap && !reg_wr) |=> (year_reg == 8'h00) && (century_reg != $past(century_reg)))
        else $error("century flag missed the year wrap");
    chk_year_leap: assert property (
        (year_reg == 8'h00) |-> leap)
        else $error("year 00 not leap");
    chk_trim_halt: assert property (
        osc_halt_flag |=> (trim_reg == rtcc_pkg::TRIM_RESET))
        else $error("trim not zero after oscillation halt");
    chk_reserved_zero: assert property (
        (reg_rd && reg_addr == rtcc_pkg::ADDR_DAY) |=> (reg_rdata_reg[7:6] == 2'b00))
        else $error("reserved day bits read non-zero");
    chk_alarm_suppress: assert property (
        (weekly_alarm_day_enables == 7'h00) |=> !weekly_alarm_on_reg)
        else $error("weekly alarm on with no weekday enabled");

    cov_year_wrap: cover property (year_wrap);
    cov_leap_day: cover property (day_carry && day_reg == 6'h29 && month_reg == rtcc_pkg::MONTH_FEB);
    cov_trim_write: cover property (wr_trim && (sec_value == 7'h20));

endmodule

//--- test/rtcc_host_model.sv
// host side model: byte writes and reads on the register port
// assumes the serial protocol engine presents one-cycle strobes on clk_sys
`timescale 1ns/100ps
module rtcc_host_model (
    input  wire logic       clk_sys,
    output logic [3:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_reg
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ----------------------------------------
    // register cycles
    // ----------------------------------------
    // callers also pass unmapped addresses and values outside the calendar ranges
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata_reg;
    endtask
endmodule

//--- test/rtc_calendar_trim_alarm_tb.sv
// self-checking bench for the calendar, trim and weekly alarm block
// assumes the host model owns the register port; crystal tick held high
`timescale 1ns/100ps
module rtc_calendar_trim_alarm_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic       clk_sys       = 1'b0;
    logic       arst_n        = 1'b0;
    logic       xtal_tick     = 1'b1;
    logic       osc_halt_flag = 1'b0;
    logic [6:0] sec_value     = 7'h05;
    logic       day_carry     = 1'b0;
    logic [6:0] en            = 7'h00;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_reg;
    logic [7:0] year_reg;
    logic       reg_wr;
    logic       reg_rd;
    logic       second_tick_reg;
    logic       century_reg;
    logic       weekly_alarm_on_reg;
    logic [5:0] day_reg;
    logic [5:0] wa_hour_reg;
    logic [4:0] month_reg;
    logic [6:0] wa_min_reg;
    int         errors        = 0;
    int         checks        = 0;
    int         seed          = 32'hAEA09582;
    int         cyc           = 0;
    int         t0            = 0;
    int         ticks[$];

    rtcc_calendar i_rtcc_calendar (
        .clk_sys(clk_sys), .arst_n(arst_n), .xtal_tick(xtal_tick), .osc_halt_flag(osc_halt_flag),
        .sec_value(sec_value), .day_carry(day_carry), .weekly_alarm_day_enables(en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_reg(reg_rdata_reg), .second_tick_reg(second_tick_reg), .day_reg(day_reg),
        .month_reg(month_reg), .century_reg(century_reg), .year_reg(year_reg), .wa_min_reg(wa_min_reg),
        .wa_hour_reg(wa_hour_reg), .weekly_alarm_on_reg(weekly_alarm_on_reg)
    );

    rtcc_host_model i_rtcc_host_model (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg)
    );

    // ----------------------------------------
    // clock, tick log, watchdog
    // ----------------------------------------
    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (second_tick_reg === 1'b1) begin
            ticks.push_back(cyc);
        end
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic int bin(input logic [7:0] v);
        return v[7:4] * 10 + v[3:0];
    endfunction

    function automatic logic [7:0] bcd(input int b);
        return {4'(b / 10), 4'(b % 10)};
    endfunction

    function automatic logic [7:0] month_end(input logic [4:0] m, input logic [7:0] y);
        case (m)
            5'h02:                      return (bin(y) % 4 == 0) ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [7:0] d;
        i_rtcc_host_model.rd(a, d);
        cmp(32'(d), 32'(e), what);
    endtask

    task automatic pulse();
        @(posedge clk_sys);
        day_carry <= 1'b1;
        @(posedge clk_sys);
        day_carry <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic cal_step(input logic [4:0] m, input logic [7:0] y);
        logic [7:0] last;
        logic [7:0] yn;
        logic [7:0] mn;
        last = month_end(m, y);
        yn = (m != 5'h12) ? y : (y == 8'h99) ? 8'h00 : bcd(bin(y) + 1);
        mn = (m == 5'h12) ? 8'h01 : bcd(bin(8'(m)) + 1);
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_YEAR, y);
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_MONTH, 8'(m));
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_DAY, bcd(bin(last) - 1));
        pulse();
        cmp(32'(day_reg), 32'(last), "day before wrap");
        pulse();
        cmp(32'(day_reg), 32'h01, "day wrap");
        cmp(32'(month_reg), 32'(mn), "month step");
        cmp(32'(year_reg), 32'(yn), "year step");
        cmp(32'(century_reg), 32'(y == 8'h99 && m == 5'h12), "century");
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        static logic [7:0] rw[6] = '{8'hC5, 8'hE3, 8'h47, 8'hFE, 8'hD9, 8'hF2};
        static logic [7:0] rx[6] = '{8'h05, 8'h83, 8'h47, 8'h7E, 8'h59, 8'h32};
        static logic [3:0] un[4] = '{4'h0, 4'h3, 4'hA, 4'hF};
        static logic [7:0] fy[6] = '{8'h24, 8'h00, 8'h10, 8'h96, 8'h99, 8'h19};
        logic [7:0] v;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        t0 = cyc + 1;
        chk_rd(rtcc_pkg::ADDR_TRIM, 8'h00, "trim reset");
        for (int i = 0; i < 6; i++) begin
            i_rtcc_host_model.wr(rtcc_pkg::ADDR_DAY + 4'(i), rw[i]);
            chk_rd(rtcc_pkg::ADDR_DAY + 4'(i), rx[i], "register readback");
        end
        cmp(32'(wa_hour_reg), 32'h32, "alarm hour noon");
        for (int i = 0; i < 8; i++) begin
            v = bcd({$random(seed)} % 60);
            v[7] = 1'($random(seed));
            i_rtcc_host_model.wr(rtcc_pkg::ADDR_WA_MINUTE, v);
            chk_rd(rtcc_pkg::ADDR_WA_MINUTE, {1'b0, v[6:0]}, "alarm minute");
            cmp(32'(wa_min_reg), 32'(v[6:0]), "alarm minute output");
            v = bcd({$random(seed)} % 24);
            v[7:6] = 2'($random(seed));
            i_rtcc_host_model.wr(rtcc_pkg::ADDR_WA_HOUR, v);
            chk_rd(rtcc_pkg::ADDR_WA_HOUR, {2'b00, v[5:0]}, "alarm hour");
        end
        foreach (un[i]) begin
            i_rtcc_host_model.wr(un[i], 8'hFF);
            chk_rd(un[i], 8'h00, "unmapped read");
        end
        chk_rd(rtcc_pkg::ADDR_DAY, 8'h05, "day after unmapped writes");
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_TRIM, 8'h55);
        @(posedge clk_sys);
        osc_halt_flag <= 1'b1;
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_TRIM, 8'h22);
        @(posedge clk_sys);
        osc_halt_flag <= 1'b0;
        chk_rd(rtcc_pkg::ADDR_TRIM, 8'h00, "trim after halt");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            en <= (i == 0) ? 7'h00 : 7'($random(seed));
            repeat (3) @(posedge clk_sys);
            cmp(32'(weekly_alarm_on_reg), 32'(|en), "weekday gate");
        end
        $display("test registers done");
        for (int i = 1; i <= 12; i++) begin
            cal_step(5'(bcd(i)), 8'h23);
        end
        foreach (fy[i]) begin
            cal_step((i < 4) ? 5'h02 : 5'h12, fy[i]);
        end
        $display("test calendar done");
        @(posedge clk_sys);
        sec_value <= 7'h20;
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_TRIM, 8'h7E);
        for (int k = 0; k < 70000 && ticks.size() < 2; k++) @(posedge clk_sys);
        @(posedge clk_sys);
        sec_value <= 7'h15;
        i_rtcc_host_model.wr(rtcc_pkg::ADDR_TRIM, 8'h07);
        @(posedge clk_sys);
        sec_value <= 7'h40;
        for (int k = 0; k < 40000 && ticks.size() < 3; k++) @(posedge clk_sys);
        cmp(32'(ticks[0] - t0), 32'(rtcc_pkg::XTAL_HZ), "second of trim write");
        cmp(32'(ticks[1] - ticks[0]), 32'(rtcc_pkg::XTAL_HZ - 2 * ((6'h3E ^ 6'h3F) + 1)), "short second");
        cmp(32'(ticks[2] - ticks[1]), 32'(rtcc_pkg::XTAL_HZ + 2 * (7 - 1)), "long second");
        $display("test trim done");
        print_verdict();
    end
endmodule
